/* hdl/pdl_params.svh */
// pdl_params.svh: constants of the divider and lock detect block
// assumes: included by bare name from the block's package and modules
`ifndef PDL_PARAMS_SVH
`define PDL_PARAMS_SVH

// --------------------------------------------------------------------
// counter widths
// --------------------------------------------------------------------
`define PDL_R_W        14
`define PDL_A_W        6
`define PDL_B_W        13
`define PDL_PRE_W      6
`define PDL_MEAS_W     8

// --------------------------------------------------------------------
// prescaler mode field codes
// --------------------------------------------------------------------
`define PDL_PS_FD1     3'h0
`define PDL_PS_FD2     3'h1
`define PDL_PS_FD3     3'h2
`define PDL_PS_DM2     3'h3
`define PDL_PS_DM4     3'h4
`define PDL_PS_DM8     3'h5
`define PDL_PS_DM16    3'h6
`define PDL_PS_DM32    3'h7

// --------------------------------------------------------------------
// pin multiplexer codes
// --------------------------------------------------------------------
`define PDL_LD_OFF     6'h00
`define PDL_LD_DLD     6'h01
`define PDL_LD_CSRC    6'h04
`define PDL_MUX_DLD    6'h01
`define PDL_MUX_CMP_HI 6'h02
`define PDL_MUX_CMP_LO 6'h03
`define PDL_MUX_DLD_LO 6'h04

// --------------------------------------------------------------------
// lock detector timing
// --------------------------------------------------------------------
`define PDL_CLK_PS     4000
`define PDL_LK_HI_NS   32
`define PDL_LK_LO_NS   16
`define PDL_ABP_NS     4
`define PDL_NS2CYC(n)  (((n) * 1000) / `PDL_CLK_PS)
`define PDL_LKCNT_0    8'h05
`define PDL_LKCNT_1    8'h10
`define PDL_LKCNT_2    8'h40
`define PDL_LKCNT_3    8'hFF
`define PDL_DLY_TAPS   7

`endif

/* hdl/pdl_pkg.sv */
// pdl_pkg: types shared by the divider and lock detect block
// assumes: pdl_params.svh sits on the include path
`include "pdl_params.svh"

package pdl_pkg;
  typedef logic [`PDL_R_W-1:0]    pdl_rdiv_t;  // reference terminal value
  typedef logic [`PDL_A_W-1:0]    pdl_adiv_t;  // swallow count
  typedef logic [`PDL_B_W-1:0]    pdl_bdiv_t;  // main count
  typedef logic [`PDL_MEAS_W-1:0] pdl_meas_t;  // edge distance in cycles
  // phase measure states
  typedef enum logic [1:0]
  {
    PDL_ST_IDLE,
    PDL_ST_WAIT_FB,
    PDL_ST_WAIT_REF
  } pdl_meas_st_t;
endpackage

/* hdl/pdl_delay_cell.sv */
// pdl_delay_cell: programmable delay for one phase detector input pulse
// assumes: one-cycle input pulses on mclk_i, code stable while in use
`include "pdl_params.svh"

module pdl_delay_cell
(
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  // control
  input  wire logic       en_i,
  input  wire logic [2:0] code_i,
  // pulse path
  input  wire logic       tick_i,
  output logic            tick_o
);
  import pdl_pkg::*;

  logic [`PDL_DLY_TAPS-1:0] tap_r;  // delay line taps

  // --------------------------------------------------------------------
  // tap line
  // --------------------------------------------------------------------
  // shift the pulse one tap per cycle
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      tap_r <= '0;
    else
      tap_r <= {tap_r[`PDL_DLY_TAPS-2:0], tick_i};
  end

  // pick the undelayed pulse or the coded tap
  always_comb
  begin
    if (!en_i || code_i == 3'h0)
      tick_o = tick_i;
    else
      tick_o = tap_r[code_i - 3'h1];
  end
endmodule

/* hdl/pdl_top.sv */
// pdl_top: reference divider, feedback divider and digital lock detect
// assumes: ref and vco clocks arrive as slow pins sampled on mclk_i,
// configuration ports are static levels from the control logic
`include "pdl_params.svh"

// Notes on behaviour
// - reference divider is fourteen bits, full range
// - reference value zero divides like one
// - divider outputs feed the two detector inputs
// - shared reset or sync clears reference divider
// - feedback ratio is modulus times main plus swallow
// - prescaler fixed one/two/three or dual modulus
// - fixed mode ignores the swallow count
// - main bypass gives one, fixed mode only
// - swallow zero means no extra cycles
// - shared reset or sync clears swallow and main
// - gated sync pin resets all divider counters, default off
// - each divider path has enabled three-bit delay
// - lock below lock window, loss above unlock
// - windows follow range and pulse width only
// - lock after programmed run of good cycles
// - lock holds until one cycle exceeds unlock
// - lock appears on lock, status, monitor pins
// - current source mode follows lock on pin
// - comparator result selectable either polarity
// - two-bit pulse width also shifts windows
module pdl_top
(
  // clock and reset
  input  wire logic               mclk_i,
  input  wire logic               sys_rst_i,
  // clock and comparator pins
  input  wire logic               ref_clk_i,
  input  wire logic               vco_clk_i,
  input  wire logic               sync_n_i,
  input  wire logic               ld_cmp_i,
  // divider configuration
  input  wire pdl_pkg::pdl_rdiv_t r_div_i,
  input  wire pdl_pkg::pdl_adiv_t a_div_i,
  input  wire pdl_pkg::pdl_bdiv_t b_div_i,
  input  wire logic [2:0]         ps_mode_i,
  input  wire logic               b_bypass_i,
  input  wire logic               cnt_rst_i,
  input  wire logic [1:0]         sync_ctl_i,
  // delay cells
  input  wire logic               ref_dly_en_i,
  input  wire logic [2:0]         ref_dly_code_i,
  input  wire logic               fb_dly_en_i,
  input  wire logic [2:0]         fb_dly_code_i,
  // lock detect configuration
  input  wire logic               win_range_i,
  input  wire logic [1:0]         abp_sel_i,
  input  wire logic [1:0]         lk_cnt_sel_i,
  // pin multiplexers
  input  wire logic [5:0]         ld_pin_sel_i,
  input  wire logic [5:0]         status_sel_i,
  input  wire logic [4:0]         mon_sel_i,
  // detector inputs
  output logic                    pfd_ref_o,
  output logic                    pfd_fb_o,
  // lock outputs
  output logic                    lock_o,
  output logic                    lock_indicator_pin_o,
  output logic                    ld_src_en_o,
  output logic                    ld_gnd_o,
  output logic                    status_o,
  output logic                    monitor_pin_o
);
  import pdl_pkg::*;

  // --------------------------------------------------------------------
  // functions
  // --------------------------------------------------------------------
  // prescaler base modulus for a mode code
  function automatic logic [`PDL_PRE_W-1:0] pre_mod(input logic [2:0] mode);
    unique case (mode)
      `PDL_PS_FD1:  pre_mod = 6'h01;
      `PDL_PS_FD2:  pre_mod = 6'h02;
      `PDL_PS_FD3:  pre_mod = 6'h03;
      `PDL_PS_DM2:  pre_mod = 6'h02;
      `PDL_PS_DM4:  pre_mod = 6'h04;
      `PDL_PS_DM8:  pre_mod = 6'h08;
      `PDL_PS_DM16: pre_mod = 6'h10;
      `PDL_PS_DM32: pre_mod = 6'h20;
    endcase
  endfunction

  // window in cycles from range bit and pulse width code
  function automatic pdl_meas_t win_cyc(input logic rng, input logic [1:0] abp,
                                        input logic wide);
    pdl_meas_t base;
    base = rng ? 8'(`PDL_NS2CYC(`PDL_LK_LO_NS)) : 8'(`PDL_NS2CYC(`PDL_LK_HI_NS));
    base = base + 8'({6'h00, abp} * 8'(`PDL_NS2CYC(`PDL_ABP_NS)));
    win_cyc = wide ? 8'(base << 1) : base;
  endfunction

  // status and monitor pin multiplexer
  function automatic logic pin_mux(input logic [5:0] code, input logic lk,
                                   input logic cmp);
    unique case (code)
      `PDL_MUX_DLD:    pin_mux = lk;
      `PDL_MUX_CMP_HI: pin_mux = cmp;
      `PDL_MUX_CMP_LO: pin_mux = ~cmp;
      `PDL_MUX_DLD_LO: pin_mux = ~lk;
      default:         pin_mux = 1'b0;
    endcase
  endfunction

  // --------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------
  logic [3:0] pin_raw;     // ref, vco, sync, comparator
  logic [3:0] meta_r;      // first stage
  logic [3:0] sync_r;      // second stage
  logic [3:0] prev_r;      // for edge detect
  logic       ref_edge;    // ref rising edge
  logic       vco_edge;    // vco rising edge
  logic       sync_clr;    // gated sync pin reset
  logic       cnt_clr;     // counter clear

  assign pin_raw = {ld_cmp_i, sync_n_i, vco_clk_i, ref_clk_i};

  // two flops, then a history flop for edges
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      meta_r <= 4'h4;
      sync_r <= 4'h4;
      prev_r <= 4'h4;
    end
    else
    begin
      meta_r <= pin_raw;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign ref_edge = sync_r[0] & ~prev_r[0];
  assign vco_edge = sync_r[1] & ~prev_r[1];
  // sync pin acts only when its control field is non-zero
  assign sync_clr = (sync_ctl_i != 2'h0) & ~sync_r[2];
  assign cnt_clr  = cnt_rst_i | sync_clr;

  // --------------------------------------------------------------------
  // reference divider
  // --------------------------------------------------------------------
  pdl_rdiv_t ref_cnt_r;   // reference edge count
  pdl_rdiv_t r_term;      // terminal count
  logic      ref_tick;    // divided reference pulse

  // zero and one both give terminal zero
  assign r_term   = (r_div_i == '0) ? '0 : r_div_i - 14'h0001;
  assign ref_tick = ref_edge & (ref_cnt_r >= r_term) & ~cnt_clr;

  // fourteen-bit counter over reference edges
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      ref_cnt_r <= '0;
    else if (cnt_clr)
      ref_cnt_r <= '0;
    else if (ref_edge)
    begin
      if (ref_cnt_r >= r_term)
        ref_cnt_r <= '0;
      else
        ref_cnt_r <= ref_cnt_r + 14'h0001;
    end
  end

  // --------------------------------------------------------------------
  // feedback divider
  // --------------------------------------------------------------------
  logic                  fixed_divide_mode;  // prescaler in fixed mode
  logic                  swallow;            // this cycle uses modulus plus one
  logic [`PDL_PRE_W-1:0] pre_cnt_r;          // prescaler count
  logic [`PDL_PRE_W-1:0] pre_term;           // prescaler terminal
  pdl_adiv_t             a_cnt_r;            // swallow count so far
  pdl_bdiv_t             b_cnt_r;            // main count so far
  pdl_bdiv_t             b_term;             // main terminal
  logic                  pre_tick;           // prescaler output pulse
  logic                  fb_tick;            // divided feedback pulse

  assign fixed_divide_mode = (ps_mode_i <= `PDL_PS_FD3);
  // swallow count is ignored in fixed mode, zero adds nothing
  assign swallow  = ~fixed_divide_mode & (a_cnt_r < a_div_i);
  assign pre_term = pre_mod(ps_mode_i) + {5'h00, swallow} - 6'h01;
  assign pre_tick = vco_edge & (pre_cnt_r >= pre_term) & ~cnt_clr;
  // bypass gives a main count of one, only in fixed mode
  assign b_term   = (fixed_divide_mode & b_bypass_i) || (b_div_i == '0) ? '0
                    : b_div_i - 13'h0001;
  assign fb_tick  = pre_tick & (b_cnt_r >= b_term);

  // prescaler counts vco edges
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      pre_cnt_r <= '0;
    else if (cnt_clr)
      pre_cnt_r <= '0;
    else if (vco_edge)
      pre_cnt_r <= pre_tick ? '0 : pre_cnt_r + 6'h01;
  end

  // swallow counter runs during the first prescaler cycles
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      a_cnt_r <= '0;
    else if (cnt_clr || fb_tick)
      a_cnt_r <= '0;
    else if (pre_tick && swallow)
      a_cnt_r <= a_cnt_r + 6'h01;
  end

  // main counter counts prescaler pulses
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      b_cnt_r <= '0;
    else if (cnt_clr || fb_tick)
      b_cnt_r <= '0;
    else if (pre_tick)
      b_cnt_r <= b_cnt_r + 13'h0001;
  end

  // --------------------------------------------------------------------
  // delay cells toward the detector
  // --------------------------------------------------------------------
  logic [1:0] dly_in;     // ref, feedback pulses
  logic [1:0] dly_out;    // delayed pulses
  logic [1:0] dly_en;     // per path enable
  logic [5:0] dly_code;   // per path code

  assign dly_in   = {fb_tick, ref_tick};
  assign dly_en   = {fb_dly_en_i, ref_dly_en_i};
  assign dly_code = {fb_dly_code_i, ref_dly_code_i};

  // one cell per divider path
  for (genvar gi = 0; gi < 2; gi++)
  begin : g_dly
    pdl_delay_cell u_cell
    (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .en_i      (dly_en[gi]),
      .code_i    (dly_code[gi*3 +: 3]),
      .tick_i    (dly_in[gi]),
      .tick_o    (dly_out[gi])
    );
  end

  assign pfd_ref_o = dly_out[0];
  assign pfd_fb_o  = dly_out[1];

  // --------------------------------------------------------------------
  // edge distance measure
  // --------------------------------------------------------------------
  pdl_meas_st_t meas_st_r;   // which edge is awaited
  pdl_meas_t    meas_cnt_r;  // cycles since first edge
  pdl_meas_t    lock_thr;    // lock window
  pdl_meas_t    unlock_thr;  // unlock window
  pdl_meas_t    meas_diff;   // measured distance
  logic         meas_done;   // a pair was compared
  logic         meas_late;   // second edge overdue

  assign lock_thr   = win_cyc(win_range_i, abp_sel_i, 1'b0);
  assign unlock_thr = win_cyc(win_range_i, abp_sel_i, 1'b1);
  assign meas_diff  = (meas_st_r == PDL_ST_IDLE) ? '0 : meas_cnt_r + 8'h01;

  // pair the edges of the two detector inputs
  always_comb
  begin
    meas_done = 1'b0;
    meas_late = 1'b0;
    unique case (meas_st_r)
      PDL_ST_IDLE:     meas_done = pfd_ref_o & pfd_fb_o;
      PDL_ST_WAIT_FB:  meas_done = pfd_fb_o;
      PDL_ST_WAIT_REF: meas_done = pfd_ref_o;
    endcase
    if (meas_st_r != PDL_ST_IDLE && !meas_done && meas_diff > unlock_thr)
      meas_late = 1'b1;
  end

  // state of the pairing
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      meas_st_r <= PDL_ST_IDLE;
    else if (meas_done || meas_late)
      meas_st_r <= PDL_ST_IDLE;
    else if (meas_st_r == PDL_ST_IDLE && pfd_ref_o)
      meas_st_r <= PDL_ST_WAIT_FB;
    else if (meas_st_r == PDL_ST_IDLE && pfd_fb_o)
      meas_st_r <= PDL_ST_WAIT_REF;
  end

  // distance counter, saturating
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      meas_cnt_r <= '0;
    else if (meas_st_r == PDL_ST_IDLE)
      meas_cnt_r <= '0;
    else if (meas_cnt_r != 8'hFF)
      meas_cnt_r <= meas_cnt_r + 8'h01;
  end

  // --------------------------------------------------------------------
  // lock decision
  // --------------------------------------------------------------------
  pdl_meas_t good_cnt_r;  // consecutive good cycles
  pdl_meas_t lk_need;     // good cycles needed
  logic      in_lock;     // this pair inside lock window
  logic      lk_fail;     // this pair beyond unlock window
  logic      hit_lock;    // run complete
  logic      dld_r;       // digital_lock_detect state

  assign in_lock  = meas_done & (meas_diff < lock_thr);
  assign lk_fail  = (meas_done & (meas_diff > unlock_thr)) | meas_late;
  assign hit_lock = in_lock & ((good_cnt_r + 8'h01) >= lk_need);

  // consecutive cycles required
  always_comb
  begin
    unique case (lk_cnt_sel_i)
      2'h0: lk_need = `PDL_LKCNT_0;
      2'h1: lk_need = `PDL_LKCNT_1;
      2'h2: lk_need = `PDL_LKCNT_2;
      2'h3: lk_need = `PDL_LKCNT_3;
    endcase
  end

  // run counter of good cycles
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      good_cnt_r <= '0;
    else if (lk_fail || (meas_done && !in_lock))
      good_cnt_r <= '0;
    else if (in_lock && good_cnt_r != 8'hFF)
      good_cnt_r <= good_cnt_r + 8'h01;
  end

  // lock set after the run, cleared by one bad cycle
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      dld_r <= 1'b0;
    else if (lk_fail)
      dld_r <= 1'b0;
    else if (hit_lock)
      dld_r <= 1'b1;
  end

  assign lock_o = dld_r;

  // --------------------------------------------------------------------
  // output pin multiplexers
  // --------------------------------------------------------------------
  logic ld_cmp;  // synchronised pin comparator

  assign ld_cmp = sync_r[3];

  // registered pin levels
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      lock_indicator_pin_o <= 1'b0;
      ld_src_en_o          <= 1'b0;
      ld_gnd_o             <= 1'b1;
      status_o             <= 1'b0;
      monitor_pin_o        <= 1'b0;
    end
    else
    begin
      lock_indicator_pin_o <= ((ld_pin_sel_i == `PDL_LD_DLD)
                              || (ld_pin_sel_i == `PDL_LD_CSRC)) & dld_r;
      ld_src_en_o          <= (ld_pin_sel_i == `PDL_LD_CSRC) & dld_r;
      ld_gnd_o             <= ~((ld_pin_sel_i == `PDL_LD_CSRC) & dld_r);
      status_o             <= pin_mux(status_sel_i, dld_r, ld_cmp);
      monitor_pin_o        <= pin_mux({1'b0, mon_sel_i}, dld_r, ld_cmp);
    end
  end

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  a_ref_clear: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    cnt_clr |=> (ref_cnt_r == '0))
    else $error("reference divider not cleared");

  a_rdiv_unity: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (ref_edge && r_div_i <= 14'h0001 && !cnt_clr) |-> ref_tick)
    else $error("reference zero or one not dividing by one");

  a_fb_clear: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    cnt_clr |=> (a_cnt_r == '0 && b_cnt_r == '0 && pre_cnt_r == '0))
    else $error("feedback counters not cleared");

  a_sync_gate: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (sync_ctl_i == 2'h0 && !cnt_rst_i && ref_edge && ref_cnt_r < r_term)
      |=> (ref_cnt_r == $past(ref_cnt_r) + 14'h0001))
    else $error("sync pin acted while disabled");

  a_fixed_noswal: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    fixed_divide_mode |-> (pre_term == pre_mod(ps_mode_i) - 6'h01))
    else $error("swallow used in fixed mode");

  a_main_term: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    fb_tick |=> (b_cnt_r == '0 && a_cnt_r == '0))
    else $error("feedback cycle did not restart");

  a_lock_run: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    $rose(dld_r) |-> ($past(in_lock) && ($past(good_cnt_r) + 8'h01 >= $past(lk_need))))
    else $error("lock without full good run");

  a_unlock_one: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (dld_r && meas_done && meas_diff > unlock_thr) |=> !dld_r)
    else $error("lock kept after bad cycle");

  a_lock_hold: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (dld_r && !lk_fail) |=> dld_r)
    else $error("lock dropped without bad cycle");

  a_csrc_pin: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (ld_pin_sel_i == `PDL_LD_CSRC) ##1 (ld_pin_sel_i == `PDL_LD_CSRC)
      |-> (ld_src_en_o == $past(dld_r) && ld_gnd_o == !$past(dld_r)))
    else $error("current source pin not following lock");
endmodule

/* bench/pdl_clk_src.sv */
// pdl_clk_src: reference source and oscillator pins for the bench
// assumes: stepped on mclk_i, half_i of at least 2 cycles
module pdl_clk_src
(
  // clock
  input  wire logic       mclk_i,
  // control
  input  wire logic       run_i,
  input  wire logic [7:0] half_i,
  input  wire logic [7:0] lag_i,
  // pins
  output logic            ref_o,
  output logic            vco_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int         t;              // cycles since the run began
  logic [7:0] lag_r = 8'h00;  // lag in use, swapped only while both pins are low
  // both pins rest low outside a run; oscillator trails by lag_r
  // a new lag is taken just before the reference rises, so no stray edge appears
  always @(posedge mclk_i)
  begin
    t     <= run_i ? t + 1 : 0;
    ref_o <= run_i && ((t / half_i) % 2 == 1);
    vco_o <= run_i && (t >= lag_r) && (((t - lag_r) / half_i) % 2 == 1);
    if (t % (2 * half_i) == half_i - 1)
      lag_r <= lag_i;
  end
endmodule

/* bench/pdl_top_tb.sv */
// pdl_top_tb: divider ratios, counter resets, lock detect, pin muxes
// assumes: pdl_top and pdl_clk_src compiled before this file
`define CHK(nm, e, g) begin compares++; if ((e) !== (g)) begin err_total++; \
  $display("wrong value %s exp %0d got %0d", nm, e, g); end end
module pdl_top_tb;
  import pdl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 0, sys_rst_i = 1, sync_n_i = 1, ld_cmp_i = 0, b_bypass_i = 0, cnt_rst_i = 0;
  logic ref_dly_en_i = 0, fb_dly_en_i = 0, win_range_i = 0, run = 0;
  logic [2:0] ps_mode_i = 0, ref_dly_code_i = 7, fb_dly_code_i = 7;
  logic [1:0] sync_ctl_i = 0, abp_sel_i = 0, lk_cnt_sel_i = 0;
  logic [5:0] ld_pin_sel_i = 0, status_sel_i = 0;
  logic [4:0] mon_sel_i = 0;
  logic [7:0] half = 2, lag = 0;
  pdl_rdiv_t r_div_i = 1;
  pdl_adiv_t a_div_i = 0;
  pdl_bdiv_t b_div_i = 3;
  logic ref_clk_i, vco_clk_i, pfd_ref_o, pfd_fb_o, lock_o, lock_indicator_pin_o;
  logic ld_src_en_o, ld_gnd_o, status_o, monitor_pin_o;
  int err_total = 0, compares = 0, seed, n, a, b;
  int pv[8] = '{1, 2, 3, 2, 4, 8, 16, 32};   // prescaler modulus by mode
  int need[4] = '{5, 16, 64, 255};            // good pairs before lock
  pdl_top dut_u (.mclk_i, .sys_rst_i, .ref_clk_i, .vco_clk_i, .sync_n_i, .ld_cmp_i, .r_div_i, .a_div_i,
    .b_div_i, .ps_mode_i, .b_bypass_i, .cnt_rst_i, .sync_ctl_i, .ref_dly_en_i, .ref_dly_code_i, .fb_dly_en_i,
    .fb_dly_code_i, .win_range_i, .abp_sel_i, .lk_cnt_sel_i, .ld_pin_sel_i, .status_sel_i, .mon_sel_i,
    .pfd_ref_o, .pfd_fb_o, .lock_o, .lock_indicator_pin_o, .ld_src_en_o, .ld_gnd_o, .status_o, .monitor_pin_o);
  pdl_clk_src src_u (.mclk_i(mclk_i), .run_i(run), .half_i(half), .lag_i(lag), .ref_o(ref_clk_i), .vco_o(vco_clk_i));
  // ----------------------------------------
  // clock and watchdog
  // ----------------------------------------
  initial
  begin
    forever #2 mclk_i = ~mclk_i;
  end
  initial
  begin
    repeat (100000) @(posedge mclk_i);
    err_total++;
    wrap_up();
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // pin edges from one detector pulse to the next, bounded
  task automatic gap(input bit fb, output int e);
    int k;
    bit p;
    bit c;
    e = 0;
    k = 0;
    while (!(fb ? pfd_fb_o : pfd_ref_o) && k < 9000)
    begin
      @(negedge mclk_i);
      k++;
    end
    p = fb ? vco_clk_i : ref_clk_i;
    do
    begin
      @(negedge mclk_i);
      k++;
      c = fb ? vco_clk_i : ref_clk_i;
      if (c && !p) e++;
      p = c;
    end while (!(fb ? pfd_fb_o : pfd_ref_o) && k < 9000);
    if (k >= 9000) err_total++;
  endtask
  // skip one period after a change, then measure
  task automatic meas(input bit fb, output int e);
    gap(fb, e);
    gap(fb, e);
  endtask
  task automatic pairs(input int k);
    int e;
    repeat (k) gap(0, e);
  endtask
  // detector pulses seen over 100 cycles
  task automatic quiet(output int e);
    e = 0;
    repeat (100)
    begin
      @(negedge mclk_i);
      e += pfd_ref_o + pfd_fb_o;
    end
  endtask
  // every mux code against the lock level lk
  task automatic mux_chk(input int lk);
    int cmp;
    int mx;
    for (int c = 0; c < 5; c++)
    begin
      cmp = {$random(seed)} % 2;
      @(posedge mclk_i);
      status_sel_i <= 6'(c);
      mon_sel_i    <= 5'(c);
      ld_pin_sel_i <= (c == 4) ? 6'h04 : 6'(c == 1);
      ld_cmp_i     <= cmp[0];
      repeat (6) @(negedge mclk_i);
      mx = (c == 1) ? lk : (c == 2) ? cmp : (c == 3) ? !cmp : (c == 4) ? !lk : 0;
      `CHK("status", mx, status_o)
      `CHK("monitor", mx, monitor_pin_o)
      `CHK("lock pin", (c == 1 || c == 4) && lk, lock_indicator_pin_o)
      `CHK("source", c == 4 && lk, ld_src_en_o)
      `CHK("ground", !(c == 4 && lk), ld_gnd_o)
    end
    $display("mux test done");
  endtask
  task automatic wrap_up();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    seed = 32'hE1687341;
    repeat (10) @(posedge mclk_i);
    sys_rst_i <= 0;
    run       <= 1;
    foreach (pv[i])
    begin
      if (i < 3)
      begin
        @(posedge mclk_i) r_div_i <= 14'(i * 5 / 2);
        meas(0, n);
        `CHK("ref ratio", (i == 0) ? 1 : i * 5 / 2, n)
      end
      a = (i == 3) ? 0 : {$random(seed)} % 4;
      b = 3 + {$random(seed)} % 4;  // main count kept at three or more
      @(posedge mclk_i);
      ps_mode_i <= 3'(i);
      a_div_i   <= 6'(a);
      b_div_i   <= 13'(b);
      meas(1, n);
      `CHK("fb ratio", (i < 3) ? pv[i] * b : pv[i] * b + a, n)
    end
    @(posedge mclk_i);
    ps_mode_i  <= 3'h1;
    b_bypass_i <= 1;
    meas(1, n);
    `CHK("bypass ratio", 2, n)
    @(posedge mclk_i) cnt_rst_i <= 1;
    quiet(n);
    `CHK("shared reset", 0, n)
    @(posedge mclk_i);
    cnt_rst_i <= 0;
    sync_n_i  <= 0;
    quiet(n);
    `CHK("sync off", 1, n > 0)
    @(posedge mclk_i) sync_ctl_i <= 2'h1;
    quiet(n);
    `CHK("sync on", 0, n)
    @(posedge mclk_i);
    sync_n_i  <= 1;
    ps_mode_i <= 3'h0;
    r_div_i   <= 14'h0001;
    half      <= 8'd25;  // detector period of 50 cycles stays above the unlock window
    $display("divider test done");
    foreach (need[s])
    begin
      @(posedge mclk_i);
      lk_cnt_sel_i <= 2'(s);
      lag          <= 8'd20;
      pairs(4);
      `CHK("unlocked", 0, lock_o)
      @(posedge mclk_i) lag <= 8'd0;
      n = 0;
      while (lock_o !== 1'b1 && n < need[s] + 4)
      begin
        @(negedge mclk_i);
        if (pfd_ref_o)
          n++;
      end
      `CHK("lock run", 1, n >= need[s] - 1 && n <= need[s] + 2)
    end
    mux_chk(1);
    @(posedge mclk_i) lag <= 8'd10;
    pairs(4);
    `CHK("hold lock", 1, lock_o)
    @(posedge mclk_i) lag <= 8'd20;
    pairs(2);
    `CHK("lose lock", 0, lock_o)
    mux_chk(0);
    @(posedge mclk_i);
    lk_cnt_sel_i <= 2'h0;
    lag          <= 8'd10;
    pairs(8);
    `CHK("between", 0, lock_o)
    @(posedge mclk_i) ref_dly_en_i <= 1;
    pairs(8);
    `CHK("ref delay", 1, lock_o)
    @(posedge mclk_i);
    ref_dly_en_i <= 0;
    fb_dly_en_i  <= 1;
    pairs(3);
    `CHK("fb delay", 0, lock_o)
    @(posedge mclk_i);
    fb_dly_en_i <= 0;
    abp_sel_i   <= 2'h3;
    pairs(8);
    `CHK("wide window", 1, lock_o)
    @(posedge mclk_i);
    abp_sel_i   <= 2'h0;
    win_range_i <= 1;
    pairs(3);
    `CHK("low range", 0, lock_o)
    $display("lock test done");
    wrap_up();
  end
endmodule
